// ---- hw/ppsc_pkg.sv ----
package ppsc_pkg;
    // ------------------------------------------------------------
    // Counts and register map
    // ------------------------------------------------------------
    localparam int          PPSC_PORTS          = 3;
    localparam logic [15:0] PPSC_SWITCH_CFG_OFS = 16'h4134;
    localparam logic [7:0]  PPSC_SWITCH_CFG_RST = 8'hc1;
    localparam logic [7:0]  PPSC_SWITCH_CFG_DYN = 8'h41;
    localparam int          PPSC_CFG_TIME_NS    = 20;
    localparam int          PPSC_CLK_PERIOD_NS  = 5;
    localparam int          PPSC_CFG_CYCLES     =
        (PPSC_CFG_TIME_NS + PPSC_CLK_PERIOD_NS - 1) / PPSC_CLK_PERIOD_NS;
    localparam int          PPSC_CFG_CNT_W      = 4;

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        logic       wr_en;
        logic [15:0] addr;
        logic [7:0] wdata;
    } ppsc_cfg_wr_t;

    typedef struct packed {
        logic [2:0] charge_support;
        logic [1:0] fixed_device;
        logic       self_supply;
    } ppsc_straps_t;

    typedef enum logic [2:0] {
        PPSC_ST_RESET  = 3'b001,
        PPSC_ST_CONFIG = 3'b010,
        PPSC_ST_RUN    = 3'b100
    } ppsc_state_t;
endpackage

// ---- hw/ppsc_port_ctl.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppsc_port_ctl
(
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic clk_en,
    input  wire logic running,
    input  wire logic combined_mode,
    input  wire logic power_request,
    input  wire logic sense_n,
    output logic      supply_enable,
    output logic      drive_oe,
    output logic      overcurrent
);
    logic supply_reg;
    logic oc_reg;
    logic supply_next;
    logic oc_next;
    wire  trip;

    // Combined pin: sense from shared pad
    assign trip        = running && supply_reg && !sense_n;
    assign oc_next     = running && (oc_reg || trip) && power_request;
    assign supply_next = running && power_request && !oc_next;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            supply_reg <= 1'b0;
            oc_reg     <= 1'b0;
        end else if (clk_en) begin
            supply_reg <= supply_next;
            oc_reg     <= oc_next;
        end
    end

    assign supply_enable = supply_reg;
    assign overcurrent   = oc_reg;
    // Released while held in reset; open drain in combined mode
    assign drive_oe      = running && (!combined_mode || !supply_reg);
endmodule
`default_nettype wire

// ---- hw/ppsc_top.sv ----
// Notes on behaviour
// - Each port supply enable is driven low to cut power; to supply it is driven high, or released in combined mode.
// - In combined mode one pin is both the supply enable and the overcurrent sense.
// - A latched charge strap of 1 marks battery charging supported, 0 not supported.
// - Self supply detect is sampled in the configuration state after reset release.
// - After configuration the sampled supply value is frozen unless switching is on.
// - The switching register takes writes from the client port and an OTP value.
// - With self supply detect in use, fixed device state comes from a register.
// - All straps latch at power-on reset and on each rising edge of chip reset.
// - While chip reset is low all port pins are released to high impedance.
`timescale 1ns/1ps
`default_nettype none
module ppsc_top
    import ppsc_pkg::*;
(
    input  wire logic                 clock,
    input  wire logic                 sys_rst,
    input  wire logic                 clk_en,
    input  wire logic                 chip_rst_n,
    input  wire ppsc_pkg::ppsc_cfg_wr_t cfg_wr,
    input  wire logic                 otp_valid,
    input  wire logic [7:0]           otp_value,
    input  wire logic                 use_self_supply_detect,
    input  wire logic [1:0]           fixed_device_cfg,
    input  wire logic [2:0]           combined_mode,
    input  wire logic [2:0]           power_request,
    input  wire logic [2:0]           port_pin_in,
    input  wire logic [2:0]           port_overcurrent_sense_n,
    input  wire logic                 self_supply_detect,
    input  wire logic [1:0]           fixed_device_straps,
    output logic [2:0]                port_supply_enable,
    output logic [2:0]                port_supply_oe,
    output logic [2:0]                port_overcurrent,
    output logic [7:0]                local_supply_switching_cfg,
    output ppsc_pkg::ppsc_straps_t    straps,
    output logic [1:0]                fixed_device_state,
    output logic                      self_powered,
    output logic                      config_done
);
    import ppsc_pkg::*;

    // ------------------------------------------------------------
    // Reset sequencing
    // ------------------------------------------------------------
    ppsc_state_t               state_reg;
    ppsc_state_t               state_next;
    logic [PPSC_CFG_CNT_W-1:0] cnt_reg;
    logic                      chip_rst_n_reg;
    logic                      latch_reg;
    logic [7:0]                sw_cfg_reg;
    ppsc_straps_t              straps_reg;
    logic                      self_reg;
    logic [1:0]                fixed_reg;
    logic                      done_reg;
    logic [2:0]                pwr_reg;
    logic [2:0]                oe_reg;
    logic [2:0]                oc_reg;

    wire       rise       = chip_rst_n && !chip_rst_n_reg;
    wire       cfg_end    = (cnt_reg == PPSC_CFG_CNT_W'(PPSC_CFG_CYCLES - 1));
    wire       dyn_on     = (sw_cfg_reg == PPSC_SWITCH_CFG_DYN);
    wire       running    = (state_reg == PPSC_ST_RUN);
    wire       in_config  = (state_reg == PPSC_ST_CONFIG);
    wire       cfg_hit    = cfg_wr.wr_en && (cfg_wr.addr == PPSC_SWITCH_CFG_OFS);
    wire [2:0] port_en;
    wire [2:0] port_oe;
    wire [2:0] port_oc;
    wire [2:0] sense_n;

    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            PPSC_ST_RESET: begin
                if (rise) begin
                    state_next = PPSC_ST_CONFIG;
                end
            end
            PPSC_ST_CONFIG: begin
                if (!chip_rst_n) begin
                    state_next = PPSC_ST_RESET;
                end else if (cfg_end) begin
                    state_next = PPSC_ST_RUN;
                end
            end
            PPSC_ST_RUN: begin
                if (!chip_rst_n) begin
                    state_next = PPSC_ST_RESET;
                end
            end
            default: state_next = PPSC_ST_RESET;
        endcase
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_reg      <= PPSC_ST_RESET;
            cnt_reg        <= '0;
            chip_rst_n_reg <= 1'b0;
            latch_reg      <= 1'b1;
        end else if (clk_en) begin
            state_reg      <= state_next;
            chip_rst_n_reg <= chip_rst_n;
            cnt_reg        <= in_config ? cnt_reg + 1'b1 : '0;
            latch_reg      <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Straps and local supply
    // ------------------------------------------------------------
    // Latch on power-on and chip reset release
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            straps_reg <= '0;
        end else if (clk_en && (latch_reg || rise)) begin
            straps_reg.charge_support <= port_pin_in;
            straps_reg.fixed_device   <= fixed_device_straps;
            straps_reg.self_supply    <= self_supply_detect;
        end
    end

    // Switching register survives chip reset; only power-on reloads it with PPSC_SWITCH_CFG_RST
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            sw_cfg_reg <= PPSC_SWITCH_CFG_RST;
        end else if (clk_en) begin
            // Client write wins over OTP load
            if (cfg_hit) begin
                sw_cfg_reg <= cfg_wr.wdata;
            end else if (otp_valid) begin
                sw_cfg_reg <= otp_value;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            self_reg <= 1'b0;
            done_reg <= 1'b0;
        end else if (clk_en) begin
            done_reg <= running;
            if (in_config || (running && dyn_on)) begin
                self_reg <= self_supply_detect;
            end
        end
    end

    // Register source when detect in use
    wire [1:0] fixed_next = use_self_supply_detect ? fixed_device_cfg : straps_reg.fixed_device;

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            fixed_reg <= '0;
        end else if (clk_en) begin
            fixed_reg <= fixed_next;
        end
    end

    // ------------------------------------------------------------
    // Port power
    // ------------------------------------------------------------
    genvar p;
    generate
        for (p = 0; p < PPSC_PORTS; p++) begin : g_port
            // Shared pin carries sense in combined mode
            // Pad reads our own low drive until released, so mask it
            assign sense_n[p] = combined_mode[p] ? (port_pin_in[p] | oe_reg[p])
                                                 : port_overcurrent_sense_n[p];
            ppsc_port_ctl u_port (
                .clock         (clock),
                .sys_rst       (sys_rst),
                .clk_en        (clk_en),
                .running       (running),
                .combined_mode (combined_mode[p]),
                .power_request (power_request[p]),
                .sense_n       (sense_n[p]),
                .supply_enable (port_en[p]),
                .drive_oe      (port_oe[p]),
                .overcurrent   (port_oc[p])
            );
        end
    endgenerate

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            pwr_reg <= '0;
            oe_reg  <= '0;
            oc_reg  <= '0;
        end else if (clk_en) begin
            pwr_reg <= port_en;
            oe_reg  <= port_oe & {PPSC_PORTS{chip_rst_n}};
            oc_reg  <= port_oc;
        end
    end

    assign port_supply_enable         = pwr_reg;
    assign port_supply_oe             = oe_reg;
    assign port_overcurrent           = oc_reg;
    assign local_supply_switching_cfg = sw_cfg_reg;
    assign straps                     = straps_reg;
    assign fixed_device_state         = fixed_reg;
    assign self_powered               = self_reg;
    assign config_done                = done_reg;
endmodule
`default_nettype wire

// ---- verif/ppsc_port_switch.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppsc_port_switch (
    input  wire logic [2:0] supply_enable,
    input  wire logic [2:0] supply_oe,
    input  wire logic [2:0] fault,
    input  wire logic [2:0] strap_level,
    output logic      [2:0] pin_level,
    output logic      [2:0] sense_n
);
    // Strap and fault levels
    // Released pin shows the board resistor; a tripped switch pulls it low
    assign pin_level = (supply_oe & supply_enable) | (~supply_oe & ~fault & strap_level);
    assign sense_n   = ~fault;
endmodule
`default_nettype wire

// ---- verif/ppsc_chk.sv ----
`timescale 1ns/1ps
`default_nettype none
module ppsc_chk
    import ppsc_pkg::*;
(
    input wire logic                   clock,
    input wire logic                   sys_rst,
    input wire logic                   clk_en,
    input wire logic                   chip_rst_n,
    input wire ppsc_pkg::ppsc_cfg_wr_t cfg_wr,
    input wire logic                   otp_valid,
    input wire logic [7:0]             otp_value,
    input wire logic [2:0]             power_request,
    input wire logic [2:0]             port_supply_enable,
    input wire logic [2:0]             port_supply_oe,
    input wire logic [2:0]             port_overcurrent,
    input wire logic [7:0]             local_supply_switching_cfg,
    input wire ppsc_pkg::ppsc_straps_t straps,
    input wire logic                   self_powered,
    input wire logic                   config_done
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);
    wire cli_wr = cfg_wr.wr_en && cfg_wr.addr == PPSC_SWITCH_CFG_OFS;
    wire [7:0] cfg = local_supply_switching_cfg;

    cfg_reset_a: assert property ($fell(sys_rst) |-> cfg == PPSC_SWITCH_CFG_RST)
        else $error("switching cfg reset wrong");
    cfg_write_a: assert property (clk_en && chip_rst_n && cli_wr |=> cfg == $past(cfg_wr.wdata))
        else $error("client write lost");
    otp_load_a: assert property (clk_en && chip_rst_n && otp_valid && !cli_wr |=> cfg == $past(otp_value))
        else $error("otp load lost");
    cfg_hold_a: assert property (!(otp_valid || cli_wr) |=> $stable(cfg))
        else $error("switching cfg changed");
    reset_hiz_a: assert property (!chip_rst_n [*3] |-> port_supply_oe == 3'b000)
        else $error("pin driven in chip reset");
    supply_req_a: assert property ((port_supply_enable & ~$past(power_request, 2)) == 3'b000)
        else $error("supply without request");
    oc_cut_a: assert property (port_overcurrent != 3'b000 |-> ##[0:2] (port_overcurrent & port_supply_enable) == 3'b000)
        else $error("overcurrent port powered");
    straps_hold_a: assert property (config_done && $past(config_done) |-> $stable(straps))
        else $error("straps moved");
    self_frozen_a: assert property (config_done && $past(config_done) && cfg != PPSC_SWITCH_CFG_DYN
        && $past(cfg) != PPSC_SWITCH_CFG_DYN |-> $stable(self_powered))
        else $error("self supply moved");
endmodule
bind ppsc_top ppsc_chk i_chk (.clock, .sys_rst, .clk_en, .chip_rst_n, .cfg_wr, .otp_valid,
    .otp_value, .power_request, .port_supply_enable, .port_supply_oe, .port_overcurrent,
    .local_supply_switching_cfg, .straps, .self_powered, .config_done);
`default_nettype wire

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ppsc_pkg::*;
    logic         clock, sys_rst, clk_en, chip_rst_n, otp_valid, config_done;
    logic         use_self_supply_detect, self_supply_detect, self_powered;
    logic [2:0]   combined_mode, power_request, port_pin_in, port_overcurrent_sense_n, fault;
    logic [2:0]   port_supply_enable, port_supply_oe, port_overcurrent, strap;
    logic [1:0]   fixed_device_cfg, fixed_device_straps, fixed_device_state;
    logic [7:0]   otp_value, local_supply_switching_cfg;
    logic [31:0]  seed = 32'h57b8d783;
    logic [31:0]  r;
    int           n_fail = 0;
    int           n_tests = 0;
    ppsc_cfg_wr_t cfg_wr;
    ppsc_straps_t straps;
    ppsc_top i_dut (.clock, .sys_rst, .clk_en, .chip_rst_n, .cfg_wr, .otp_valid, .otp_value,
        .use_self_supply_detect, .fixed_device_cfg, .combined_mode, .power_request,
        .port_pin_in, .port_overcurrent_sense_n, .self_supply_detect, .fixed_device_straps,
        .port_supply_enable, .port_supply_oe, .port_overcurrent, .local_supply_switching_cfg,
        .straps, .fixed_device_state, .self_powered, .config_done);
    ppsc_port_switch i_sw (.supply_enable(port_supply_enable), .supply_oe(port_supply_oe),
        .fault, .strap_level(strap), .pin_level(port_pin_in), .sense_n(port_overcurrent_sense_n));
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    // Combined pins are driven only while the port is off
    function automatic logic [2:0] exp_oe(input logic [2:0] m, input logic [2:0] e);
        return ~m | ~e;
    endfunction
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // OTP carries the inverse whenever the client also writes, so priority shows
    task automatic wr(input logic w, input logic [15:0] a, input logic [7:0] d, input logic o);
        @(posedge clock);
        cfg_wr <= '{w, a, d};
        otp_valid <= o;
        otp_value <= w ? ~d : d;
        @(posedge clock);
        cfg_wr.wr_en <= 1'b0;
        otp_valid <= 1'b0;
        cyc(1);
    endtask
    task automatic chip_reset;
        r = rnd();
        @(posedge clock);
        chip_rst_n <= 1'b0;
        power_request <= 3'b000;
        fault <= 3'b000;
        {strap, fixed_device_straps, self_supply_detect} <= r[5:0];
        cyc(4);
        check("supply_oe", port_supply_oe, 3'b000);
        @(posedge clock);
        chip_rst_n <= 1'b1;
        for (int i = 0; i < 20 && config_done !== 1'b1; i++) cyc(1);
        check("config_done", config_done, 1'b1);
        check("straps", straps, r[5:0]);
        check("self_powered", self_powered, r[0]);
        check("fixed_state", fixed_device_state,
              use_self_supply_detect ? fixed_device_cfg : r[2:1]);
        @(posedge clock);
        strap <= 3'b111;
        {fixed_device_straps, self_supply_detect} <= ~r[2:0];
        cyc(6);
        check("straps held", straps, r[5:0]);
        check("self held", self_powered, r[0]);
    endtask
    task automatic results;
        if (n_fail == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    initial begin
        clock = 1'b0;
        forever #2.5 clock = ~clock;
    end
    initial begin
        #20000;
        n_fail++;
        results();
    end
    initial begin
        {sys_rst, clk_en} = 2'b11;
        {chip_rst_n, otp_valid, use_self_supply_detect, combined_mode, power_request} = '0;
        {cfg_wr, otp_value, fixed_device_cfg, fault, strap, self_supply_detect} = '0;
        fixed_device_straps = '0;
        repeat (6) @(posedge clock);
        sys_rst <= 1'b0;
        chip_reset();
        check("switch cfg", local_supply_switching_cfg, PPSC_SWITCH_CFG_RST);
        repeat (40) begin
            r = rnd();
            @(posedge clock);
            power_request <= 3'b000;
            cyc(4);
            @(posedge clock);
            {combined_mode, fault, power_request} <= r[8:0];
            cyc(8);
            check("supply_enable", port_supply_enable, r[2:0] & ~r[5:3]);
            check("overcurrent", port_overcurrent, r[2:0] & r[5:3]);
            check("supply_oe", port_supply_oe, exp_oe(r[8:6], r[2:0] & ~r[5:3]));
        end
        wr(1'b1, PPSC_SWITCH_CFG_OFS + 16'h1, PPSC_SWITCH_CFG_DYN, 1'b0);
        check("switch cfg", local_supply_switching_cfg, PPSC_SWITCH_CFG_RST);
        wr(1'b1, PPSC_SWITCH_CFG_OFS, PPSC_SWITCH_CFG_DYN, 1'b1);
        check("switch cfg", local_supply_switching_cfg, PPSC_SWITCH_CFG_DYN);
        @(posedge clock);
        self_supply_detect <= ~self_supply_detect;
        use_self_supply_detect <= 1'b1;
        fixed_device_cfg <= r[10:9];
        cyc(6);
        check("self_powered", self_powered, self_supply_detect);
        wr(1'b0, PPSC_SWITCH_CFG_OFS, PPSC_SWITCH_CFG_RST, 1'b1);
        check("switch cfg", local_supply_switching_cfg, PPSC_SWITCH_CFG_RST);
        @(posedge clock);
        self_supply_detect <= ~self_supply_detect;
        cyc(6);
        check("self frozen", self_powered, !self_supply_detect);
        // Enable low: a write and a fault must both be ignored
        @(posedge clock);
        clk_en <= 1'b0;
        cfg_wr <= '{1'b1, PPSC_SWITCH_CFG_OFS, PPSC_SWITCH_CFG_DYN};
        fault <= 3'b111;
        cyc(4);
        check("frozen cfg", local_supply_switching_cfg, PPSC_SWITCH_CFG_RST);
        check("frozen supply", port_supply_enable, r[2:0] & ~r[5:3]);
        @(posedge clock);
        clk_en <= 1'b1;
        cfg_wr.wr_en <= 1'b0;
        fault <= r[5:3];
        cyc(2);
        check("switch cfg", local_supply_switching_cfg, PPSC_SWITCH_CFG_RST);
        chip_reset();
        results();
    end
endmodule
`default_nettype wire
